// >>> hdl/tcc_pkg.sv
package tcc_pkg;
  // ****************************************
  // register indexes (byte address = 4 * index)
  // ****************************************
  localparam logic [9:0] IDX_FLAGS  = 10'h0c8;
  localparam logic [9:0] IDX_CAPCTL = 10'h0e8;
  localparam logic [9:0] IDX_TCTL   = 10'h0ea;
  localparam logic [9:0] IDX_STE    = 10'h0ee;
  localparam logic [9:0] IDX_RTE    = 10'h0ef;
  localparam logic [9:0] IDX_TIMER  = 10'h0f0;
  localparam logic [9:0] IDX_CMP0   = 10'h0f1;
  localparam logic [9:0] IDX_CAP0   = 10'h0f4;
  localparam logic [9:0] IDX_PORT   = 10'h0f8;
  // ****************************************
  // field codes and reset values
  // ****************************************
  localparam logic [1:0] SRC_OFF    = 2'h0;
  localparam logic [1:0] SRC_DIV12  = 2'h1;
  localparam logic [1:0] SRC_PIN    = 2'h3;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam int unsigned TOG_LO    = 6;
  localparam int unsigned SET_W     = 6;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ    = 50_000_000;
  localparam int unsigned SRC_DIV   = 12;
  localparam logic [3:0] DIV12_LAST = 4'(SRC_DIV - 1);
  // timer control byte, bit 7 first
  typedef struct packed {
    logic       wide_irq_sel;
    logic       byte_irq_sel;
    logic       ext_clear_en;
    logic       byte_ovf_flag;
    logic [1:0] prescale_sel;
    logic [1:0] source_sel;
  } tcc_tctl_t;
  // event flag byte, bit 7 first
  typedef struct packed {
    logic       wide_ovf;
    logic [2:0] cmp;
    logic [3:0] cap;
  } tcc_flags_t;
endpackage : tcc_pkg

// >>> hdl/tcc_top.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
// Behaviour
// - prescale code 00/01/10/11 divides the timer input by 1/2/4/8
// - source 00 stops, 01 takes clock/12, 11 takes the external clock pin
// - with external clear enabled, a rising clear-pin edge zeroes the timer
// - full 16-bit overflow requests interrupt only with wide select set
// - low byte overflow requests interrupt only with byte select set
// - control bit 4 is the byte overflow flag, set by hardware
// - even capture control bit enables rising edge capture and flag
// - odd bit enables falling edge; both bits both edges; none disables
// - each compare register is matched against the timer, setting its flag
// - compare 0 match sets port bits 0-5 that have set enable
// - each set enable bit alone gates its port bit; 0 leaves it
// - compare 1 match clears port bits 0-5 that have reset enable
// - compare 2 match toggles port bits 6 and 7 when toggle enabled
// - simultaneous compare 0 and 1 matches clear: reset wins
// - toggle state 1 makes next toggle clear, 0 makes it set
// - chip reset clears all three compare registers
// - flags: bit 7 wide overflow, 6..4 compare 2..0, 3..0 capture 3..0
// - enabled capture edge copies timer to capture register and sets flag
// - prescaler clears on factor or source change and on timer reset
// - in low power the timer and prescaler are held cleared
module tcc_top #(
  parameter int unsigned CAP_N = 4
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // pins
  input  wire logic [CAP_N-1:0] CAPTURE_IN,
  input  wire logic        EXT_CLOCK_IN,
  input  wire logic        TIMER_CLEAR_INPUT,
  input  wire logic        LOW_POWER,
  output logic      [7:0]  PORT_OUT,
  output logic             TIMER_IRQ
);
  // ****************************************
  // checks and declarations
  // ****************************************
  if (CAP_N < 1 || CAP_N > 4) begin : g_chk
    $error("CAP_N must be 1 to 4");
  end
  tcc_pkg::tcc_tctl_t  tctl_q;
  tcc_pkg::tcc_flags_t flags_q;
  logic [7:0]  capctl_q, ste_q, rte_q;
  logic [15:0] timer_q;
  logic [15:0] cmp_q [3];
  logic [15:0] cap_q [4];
  logic [3:0]  div12_q;
  logic [2:0]  pre_q, mask;
  logic [3:0]  cfg_prev_q;
  logic        ext_prev_q, clr_prev_q;
  logic [3:0]  cap_prev_q, cap_ev;
  logic [2:0]  match, match_prev_q, cmp_ev;
  logic        tick12, src_tick, ptick, ext_clr, pre_clr;
  logic        wide_ev, byte_ev;
  logic        wr;
  logic [9:0]  idx;
  logic        mapped;
  logic [7:0]  port_d;
  logic [15:0] past_timer_q;
  logic [7:0]  past_ste_q, past_rte_q;

  // ****************************************
  // apb slave
  // ****************************************
  assign idx = PADDR[11:2];
  assign wr  = PSEL & PENABLE & PWRITE & PREADY;
  // unmapped decode
  always_comb begin
    mapped = 1'b1;
    case (idx)
      tcc_pkg::IDX_FLAGS, tcc_pkg::IDX_CAPCTL, tcc_pkg::IDX_TCTL,
      tcc_pkg::IDX_STE, tcc_pkg::IDX_RTE, tcc_pkg::IDX_TIMER,
      tcc_pkg::IDX_PORT: mapped = 1'b1;
      default: mapped = (idx >= tcc_pkg::IDX_CMP0 && idx < tcc_pkg::IDX_CMP0 + 10'd3)
                     || (idx >= tcc_pkg::IDX_CAP0 && idx < tcc_pkg::IDX_CAP0 + 10'd4);
    endcase
  end
  // one wait-free access cycle, answer registered at setup
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0;
    end else begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~mapped;
      if (PSEL && !PENABLE) begin
        PRDATA <= 32'h0;
        case (idx)
          tcc_pkg::IDX_FLAGS:  PRDATA <= {24'h0, flags_q};
          tcc_pkg::IDX_CAPCTL: PRDATA <= {24'h0, capctl_q};
          tcc_pkg::IDX_TCTL:   PRDATA <= {24'h0, tctl_q};
          tcc_pkg::IDX_STE:    PRDATA <= {24'h0, ste_q};
          tcc_pkg::IDX_RTE:    PRDATA <= {24'h0, rte_q};
          tcc_pkg::IDX_TIMER:  PRDATA <= {16'h0, timer_q};
          tcc_pkg::IDX_PORT:   PRDATA <= {24'h0, PORT_OUT};
          default: begin
            if (idx >= tcc_pkg::IDX_CMP0 && idx < tcc_pkg::IDX_CMP0 + 10'd3)
              PRDATA <= {16'h0, cmp_q[2'(idx - tcc_pkg::IDX_CMP0)]};
            else if (idx >= tcc_pkg::IDX_CAP0 && idx < tcc_pkg::IDX_CAP0 + 10'd4)
              PRDATA <= {16'h0, cap_q[2'(idx - tcc_pkg::IDX_CAP0)]};
          end
        endcase
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // plain software registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      capctl_q <= tcc_pkg::RST_BYTE;
      rte_q    <= tcc_pkg::RST_BYTE;
    end else if (wr) begin
      if (idx == tcc_pkg::IDX_CAPCTL) capctl_q <= PWDATA[7:0];
      if (idx == tcc_pkg::IDX_RTE)    rte_q    <= PWDATA[7:0];
    end
  end
  // compare registers, cleared by chip reset
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int k = 0; k < 3; k++) cmp_q[k] <= tcc_pkg::RST_WORD;
    end else if (wr) begin
      for (int k = 0; k < 3; k++)
        if (idx == tcc_pkg::IDX_CMP0 + 10'(k)) cmp_q[k] <= PWDATA[15:0];
    end
  end
  // timer control, byte flag set wins over write
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tctl_q <= tcc_pkg::tcc_tctl_t'(tcc_pkg::RST_BYTE);
    end else begin
      if (wr && idx == tcc_pkg::IDX_TCTL) tctl_q <= tcc_pkg::tcc_tctl_t'(PWDATA[7:0]);
      if (byte_ev) tctl_q.byte_ovf_flag <= 1'b1;
    end
  end
  // set enable and toggle state; toggle state flips on each toggle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ste_q <= tcc_pkg::RST_BYTE;
    end else begin
      if (wr && idx == tcc_pkg::IDX_STE) ste_q <= PWDATA[7:0];
      for (int b = tcc_pkg::TOG_LO; b < 8; b++)
        if (cmp_ev[2] && rte_q[b]) ste_q[b] <= ~ste_q[b];
    end
  end

  // ****************************************
  // clock source and prescaler
  // ****************************************
  assign tick12   = (div12_q == tcc_pkg::DIV12_LAST);
  assign ext_clr  = tctl_q.ext_clear_en & TIMER_CLEAR_INPUT & ~clr_prev_q;
  // source select; code 10 treated as halted
  always_comb begin
    case (tctl_q.source_sel)
      tcc_pkg::SRC_DIV12: src_tick = tick12;
      tcc_pkg::SRC_PIN:   src_tick = EXT_CLOCK_IN & ~ext_prev_q;
      default:            src_tick = 1'b0;
    endcase
  end
  // prescale mask for /1 /2 /4 /8
  always_comb begin
    case (tctl_q.prescale_sel)
      2'h0:    mask = 3'h0;
      2'h1:    mask = 3'h1;
      2'h2:    mask = 3'h3;
      default: mask = 3'h7;
    endcase
  end
  assign ptick   = src_tick & ((pre_q & mask) == mask) & ~LOW_POWER;
  assign pre_clr = (cfg_prev_q != {tctl_q.prescale_sel, tctl_q.source_sel})
                 | ext_clr | LOW_POWER;
  // divide by 12 and pin edge history
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div12_q    <= 4'h0;
      ext_prev_q <= 1'b0;
      clr_prev_q <= 1'b0;
      cfg_prev_q <= 4'h0;
    end else begin
      div12_q    <= tick12 ? 4'h0 : div12_q + 4'h1;
      ext_prev_q <= EXT_CLOCK_IN;
      clr_prev_q <= TIMER_CLEAR_INPUT;
      cfg_prev_q <= {tctl_q.prescale_sel, tctl_q.source_sel};
    end
  end
  // prescaler counts source ticks
  always_ff @(posedge CLK or posedge RST) begin
    if (RST)          pre_q <= 3'h0;
    else if (pre_clr) pre_q <= 3'h0;
    else if (src_tick) pre_q <= pre_q + 3'h1;
  end

  // ****************************************
  // timer and overflow
  // ****************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) timer_q <= tcc_pkg::RST_WORD;
    else if (LOW_POWER || ext_clr) timer_q <= tcc_pkg::RST_WORD;
    else if (ptick) timer_q <= timer_q + 16'h1;
  end
  assign wide_ev = ptick & ~ext_clr & (timer_q == 16'hffff);
  assign byte_ev = ptick & ~ext_clr & (timer_q[7:0] == 8'hff);
  // overflow interrupt request
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) TIMER_IRQ <= 1'b0;
    else TIMER_IRQ <= (tctl_q.wide_irq_sel & flags_q.wide_ovf)
                    | (tctl_q.byte_irq_sel & tctl_q.byte_ovf_flag);
  end

  // ****************************************
  // capture channels
  // ****************************************
  for (genvar n = 0; n < 4; n++) begin : g_cap
    if (n < CAP_N) begin : g_on
      assign cap_ev[n] = (capctl_q[2*n]   &  CAPTURE_IN[n] & ~cap_prev_q[n])
                       | (capctl_q[2*n+1] & ~CAPTURE_IN[n] &  cap_prev_q[n]);
      // edge history and capture load
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          cap_prev_q[n] <= 1'b0;
          cap_q[n]      <= tcc_pkg::RST_WORD;
        end else begin
          cap_prev_q[n] <= CAPTURE_IN[n];
          if (cap_ev[n]) cap_q[n] <= timer_q;
        end
      end
    end else begin : g_off
      assign cap_ev[n] = 1'b0;
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          cap_prev_q[n] <= 1'b0;
          cap_q[n]      <= tcc_pkg::RST_WORD;
        end else begin
          cap_prev_q[n] <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // compare channels and port
  // ****************************************
  for (genvar k = 0; k < 3; k++) begin : g_cmp
    assign match[k]  = (timer_q == cmp_q[k]);
    assign cmp_ev[k] = match[k] & ~match_prev_q[k];
  end
  // match history, starts high so reset state is no event
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) match_prev_q <= 3'h7;
    else     match_prev_q <= match;
  end
  // event flags, hardware set wins over software write
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      flags_q <= tcc_pkg::tcc_flags_t'(tcc_pkg::RST_BYTE);
    end else begin
      if (wr && idx == tcc_pkg::IDX_FLAGS) flags_q <= tcc_pkg::tcc_flags_t'(PWDATA[7:0]);
      if (wide_ev) flags_q.wide_ovf <= 1'b1;
      for (int k = 0; k < 3; k++) if (cmp_ev[k]) flags_q.cmp[k] <= 1'b1;
      for (int n = 0; n < 4; n++) if (cap_ev[n]) flags_q.cap[n] <= 1'b1;
    end
  end
  // port next value; clear after set gives reset priority
  always_comb begin
    port_d = PORT_OUT;
    if (cmp_ev[0]) port_d[5:0] = port_d[5:0] | ste_q[5:0];
    if (cmp_ev[1]) port_d[5:0] = port_d[5:0] & ~rte_q[5:0];
    for (int b = tcc_pkg::TOG_LO; b < 8; b++)
      if (cmp_ev[2] && rte_q[b]) port_d[b] = ~ste_q[b];
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) PORT_OUT <= tcc_pkg::RST_BYTE;
    else     PORT_OUT <= port_d;
  end

  // ****************************************
  // assertions
  // ****************************************
  // helper history for checks
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      past_timer_q <= 16'h0;
      past_ste_q   <= 8'h0;
      past_rte_q   <= 8'h0;
    end else begin
      past_timer_q <= timer_q;
      past_ste_q   <= ste_q;
      past_rte_q   <= rte_q;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_halt;
    (tctl_q.source_sel == tcc_pkg::SRC_OFF) && !LOW_POWER && !ext_clr |=> timer_q == past_timer_q;
  endproperty
  a_halt: assert property (p_halt) else $error("timer moved while halted");
  property p_div1;
    (tctl_q.source_sel == tcc_pkg::SRC_DIV12) && (tctl_q.prescale_sel == 2'h0) && tick12
      && !pre_clr && !ext_clr |=> timer_q == past_timer_q + 16'h1;
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one missed a tick");
  property p_extclr;
    ext_clr && !LOW_POWER |=> timer_q == 16'h0 && pre_q == 3'h0;
  endproperty
  a_extclr: assert property (p_extclr) else $error("external clear ignored");
  property p_wide_irq;
    flags_q.wide_ovf && tctl_q.wide_irq_sel |=> TIMER_IRQ;
  endproperty
  a_wide_irq: assert property (p_wide_irq) else $error("wide overflow not requested");
  property p_no_irq;
    !tctl_q.wide_irq_sel && !tctl_q.byte_irq_sel |=> !TIMER_IRQ;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("request without select");
  property p_byte_flag;
    byte_ev |=> tctl_q.byte_ovf_flag;
  endproperty
  a_byte_flag: assert property (p_byte_flag) else $error("byte flag not set");
  property p_capture;
    cap_ev[0] |=> cap_q[0] == past_timer_q && flags_q.cap[0];
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost");
  property p_reset_wins;
    cmp_ev[0] && cmp_ev[1] |=> (PORT_OUT[5:0] & past_rte_q[5:0]) == 6'h0;
  endproperty
  a_reset_wins: assert property (p_reset_wins) else $error("set beat reset");
  property p_toggle;
    cmp_ev[2] && rte_q[6] |=> PORT_OUT[6] == !past_ste_q[6] && ste_q[6] == !past_ste_q[6];
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle wrong");
  property p_once;
    cmp_ev[0] |=> !cmp_ev[0];
  endproperty
  a_once: assert property (p_once) else $error("repeated match");
  property p_lowpower;
    LOW_POWER |=> timer_q == 16'h0 && pre_q == 3'h0;
  endproperty
  a_lowpower: assert property (p_lowpower) else $error("timer runs in low power");
  property p_cmp_flag;
    cmp_ev[1] |=> flags_q.cmp[1];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag not set");
  property p_port_set;
    cmp_ev[0] && !cmp_ev[1] |=> (PORT_OUT[5:0] & past_ste_q[5:0]) == past_ste_q[5:0];
  endproperty
  a_port_set: assert property (p_port_set) else $error("set enable ignored");
  property p_port_clear;
    cmp_ev[1] |=> (PORT_OUT[5:0] & past_rte_q[5:0]) == 6'h0;
  endproperty
  a_port_clear: assert property (p_port_clear) else $error("reset enable ignored");
  property p_cfg_clear;
    cfg_prev_q != {tctl_q.prescale_sel, tctl_q.source_sel} |=> pre_q == 3'h0;
  endproperty
  a_cfg_clear: assert property (p_cfg_clear) else $error("prescaler kept its count");
  // covers for the main scenarios
  c_wide: cover property (wide_ev);
  c_capture_both: cover property (cap_ev[2] ##[1:200] cap_ev[2]);
  c_set_clear: cover property (cmp_ev[0] && cmp_ev[1]);
  c_toggle: cover property (cmp_ev[2] && rte_q[7]);
endmodule : tcc_top

// >>> dv/tcc_pin_model.sv
`timescale 1ns/1ns
// ****************************************
// pin side: external clock, clear pin, capture inputs
// ****************************************
module tcc_pin_model (
  // clock
  input  wire logic clk,
  // pins toward the block
  output logic       ext_clk,
  output logic       clr_pin,
  output logic [3:0] cap_pins
);
  // all pins start low; the external clock stands still between bursts
  initial begin
    ext_clk  = 1'b0;
    clr_pin  = 1'b0;
    cap_pins = 4'h0;
  end

  // n rising edges, period of 12 cycles to stay within the f/12 limit
  task automatic pulse_clk(input int n);
    repeat (n) begin
      @(posedge clk);
      ext_clk <= 1'b1;
      repeat (6) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (5) @(posedge clk);
    end
    repeat (2) @(posedge clk);
  endtask : pulse_clk

  // one rising edge on the external clear pin
  task automatic pulse_clr();
    @(posedge clk);
    clr_pin <= 1'b1;
    repeat (3) @(posedge clk);
    clr_pin <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse_clr

  // new capture pin levels, then time for the capture to land
  task automatic set_cap(input logic [3:0] v);
    @(posedge clk);
    cap_pins <= v;
    repeat (4) @(posedge clk);
  endtask : set_cap
endmodule : tcc_pin_model

// >>> dv/timer_capture_compare_unit_bench.sv
`timescale 1ns/1ns
module timer_capture_compare_unit_bench;
  // ****************************************
  // signals and model state
  // ****************************************
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  cap_pins;
  logic        ext_clk;
  logic        clr_pin;
  logic        low_pwr;
  logic [7:0]  port_out;
  logic        irq;
  int          err_total = 0;
  int          total_checks = 0;
  logic [31:0] lfsr_q = 32'h9ec5ac4b;
  logic [7:0]  port_m = 8'h00;
  logic [1:0]  ts_m;
  logic [5:0]  set_m;
  logic [5:0]  clr_m;
  int          cap_m[4] = '{0, 0, 0, 0};
  logic [31:0] rdv;
  logic        erv;
  localparam logic [9:0] RIDX [8] = '{tcc_pkg::IDX_FLAGS, tcc_pkg::IDX_CAPCTL, tcc_pkg::IDX_TCTL,
    tcc_pkg::IDX_STE, tcc_pkg::IDX_RTE, tcc_pkg::IDX_CMP0, tcc_pkg::IDX_CMP0 + 10'h1, tcc_pkg::IDX_CMP0 + 10'h2};

  // 50 MHz clock
  always #10 clk = ~clk;

  tcc_top dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CAPTURE_IN(cap_pins),
    .EXT_CLOCK_IN(ext_clk), .TIMER_CLEAR_INPUT(clr_pin), .LOW_POWER(low_pwr), .PORT_OUT(port_out), .TIMER_IRQ(irq));
  tcc_pin_model pins (.clk(clk), .ext_clk(ext_clk), .clr_pin(clr_pin), .cap_pins(cap_pins));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // one apb transfer, held until pready is sampled high
  task automatic apb(input bit wr, input logic [9:0] idx, input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, rdv, erv);
  endtask : wr

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, rdv, erv);
    chk(rdv, exp);
  endtask : rdchk

  // port model for compare 0/1/2 events in one cycle, clear wins
  task automatic match_m(input bit c0, input bit c1, input bit c2);
    if (c0) port_m[5:0] = port_m[5:0] | set_m;
    if (c1) port_m[5:0] = port_m[5:0] & ~clr_m;
    if (c2) begin
      port_m[7:6] = ~ts_m;
      ts_m = ~ts_m;
    end
  endtask : match_m

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // watchdog against a hang
  initial begin
    #(20 * 40000);
    err_total++;
    stop_test();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    clk     = 1'b0;
    rst     = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    low_pwr = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (RIDX[i]) rdchk(RIDX[i], 32'h0);
    apb(1'b0, 10'h000, 32'h0, rdv, erv);
    chk({erv, rdv[30:0]}, 32'h80000000);
    $display("test done: reset and map");
    // external pin source, each prescale code from a cleared timer
    for (int p = 0; p < 4; p++) begin
      wr(tcc_pkg::IDX_TCTL, 32'h23 | 32'(p << 2));
      pins.pulse_clr();
      pins.pulse_clk(16);
      rdchk(tcc_pkg::IDX_TIMER, 32'(16 >> p));
    end
    wr(tcc_pkg::IDX_TCTL, 32'h20);
    pins.pulse_clk(3);
    rdchk(tcc_pkg::IDX_TIMER, 32'h2);
    wr(tcc_pkg::IDX_TCTL, 32'h21);
    pins.pulse_clr();
    repeat (240) @(posedge clk);
    apb(1'b0, tcc_pkg::IDX_TIMER, 32'h0, rdv, erv);
    chk(32'(rdv >= 32'h13 && rdv <= 32'h15), 32'h1);
    $display("test done: timer source and prescale");
    // capture: ch0 rise, ch1 fall, ch2 both, ch3 off
    wr(tcc_pkg::IDX_TCTL, 32'h23);
    pins.pulse_clr();
    wr(tcc_pkg::IDX_FLAGS, 32'h0);
    wr(tcc_pkg::IDX_CAPCTL, 32'h39);
    pins.pulse_clk(3);
    pins.set_cap(4'hf);
    cap_m[0] = 3;
    cap_m[2] = 3;
    rdchk(tcc_pkg::IDX_FLAGS, 32'h05);
    pins.pulse_clk(4);
    wr(tcc_pkg::IDX_FLAGS, 32'h0);
    pins.set_cap(4'h0);
    cap_m[1] = 7;
    cap_m[2] = 7;
    rdchk(tcc_pkg::IDX_FLAGS, 32'h06);
    for (int i = 0; i < 4; i++) rdchk(tcc_pkg::IDX_CAP0 + 10'(i), 32'(cap_m[i]));
    $display("test done: capture");
    // compare: random set and clear enables, both toggles enabled
    lfsr_q = lfsr_next(lfsr_q);
    set_m = lfsr_q[5:0];
    clr_m = lfsr_q[13:8];
    ts_m = 2'b01;
    wr(tcc_pkg::IDX_STE, {24'h0, ts_m, set_m});
    wr(tcc_pkg::IDX_RTE, {24'h0, 2'b11, clr_m});
    wr(tcc_pkg::IDX_CMP0, 32'h5);
    wr(tcc_pkg::IDX_CMP0 + 10'h1, 32'h9);
    wr(tcc_pkg::IDX_CMP0 + 10'h2, 32'h5);
    pins.pulse_clr();
    wr(tcc_pkg::IDX_FLAGS, 32'h0);
    pins.pulse_clk(5);
    match_m(1'b1, 1'b0, 1'b1);
    chk(32'(port_out), 32'(port_m));
    rdchk(tcc_pkg::IDX_FLAGS, 32'h50);
    wr(tcc_pkg::IDX_FLAGS, 32'h0);
    repeat (8) @(posedge clk);
    rdchk(tcc_pkg::IDX_FLAGS, 32'h0);
    pins.pulse_clk(4);
    match_m(1'b0, 1'b1, 1'b0);
    chk(32'(port_out), 32'(port_m));
    rdchk(tcc_pkg::IDX_FLAGS, 32'h20);
    for (int i = 0; i < 3; i++) wr(tcc_pkg::IDX_CMP0 + 10'(i), 32'hc);
    wr(tcc_pkg::IDX_FLAGS, 32'h0);
    pins.pulse_clk(3);
    match_m(1'b1, 1'b1, 1'b1);
    chk(32'(port_out), 32'(port_m));
    rdchk(tcc_pkg::IDX_FLAGS, 32'h70);
    $display("test done: compare");
    // byte overflow flag and interrupt selects
    pins.pulse_clr();
    wr(tcc_pkg::IDX_TCTL, 32'h23);
    pins.pulse_clk(256);
    rdchk(tcc_pkg::IDX_TCTL, 32'h33);
    chk(32'(irq), 32'h0);
    wr(tcc_pkg::IDX_TCTL, 32'h73);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h1);
    wr(tcc_pkg::IDX_TCTL, 32'hb3);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    rdchk(tcc_pkg::IDX_TIMER, 32'h100);
    // low power holds the timer cleared
    low_pwr <= 1'b1;
    pins.pulse_clk(2);
    rdchk(tcc_pkg::IDX_TIMER, 32'h0);
    low_pwr <= 1'b0;
    $display("test done: overflow and low power");
    // chip reset in mid-run clears the compare registers written above
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) rdchk(tcc_pkg::IDX_CMP0 + 10'(i), 32'h0);
    chk(32'(port_out), 32'h0);
    $display("test done: mid-run reset");
    stop_test();
  end
endmodule : timer_capture_compare_unit_bench
